//--- core/txc_chan_tx.sv
`timescale 1ns/1ps
module txc_chan_tx
    import txc_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  reset,
    txc_word_if.dst    w,
    output logic       tx_p,
    output logic       tx_n,
    output logic       tx_oe_n,
    output logic       overrun
);

    typedef struct packed {
        txc_ser_t    st;
        logic [3:0]  cnt;
        logic [9:0]  sh;
        logic        rd;
        logic        p;
        logic        n;
        logic        oe_n;
        logic        ovr;
    } txc_chs_t;

    txc_chs_t     q;
    txc_chs_t     d;
    logic [10:0]  enc;
    logic [9:0]   cw;
    logic         load;
    logic         lsb_in;
    logic         msb_in;

    assign load   = w.valid && q.st == TXC_IDLE;
    assign lsb_in = w.word[0];
    assign msb_in = w.word[9];

    // ==========================================================
    // Encode or pass raw, then shift out one bit per clock
    always_comb begin
        d   = q;
        // Line 8 is the K flag and line 9 is dropped when encoding
        enc = txc_enc(w.word[7:0], w.word[TXC_K_BIT], q.rd);
        cw  = w.code ? enc[9:0] : w.word;
        d.oe_n = w.hiz;
        // A word arriving mid-shift is lost; flag stays until reset
        d.ovr = q.ovr | (w.valid && q.st != TXC_IDLE);
        case (q.st)
            TXC_IDLE: begin
                d.p = 1'b0;
                if (w.valid) begin
                    if (w.code)
                        d.rd = enc[10];
                    d.p   = cw[0];
                    d.sh  = {1'b0, cw[9:1]};
                    d.cnt = TXC_BITS_LAST;
                    d.st  = TXC_SHIFT;
                end
            end
            TXC_SHIFT: begin
                d.p   = q.sh[0];
                d.sh  = {1'b0, q.sh[9:1]};
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1)
                    d.st = TXC_IDLE;
            end
            default: d.st = TXC_IDLE;
        endcase
        d.n = ~d.p;
        if (reset) begin
            d      = '0;
            d.rd   = TXC_RD_RST;
            d.n    = 1'b1;
            d.oe_n = TXC_HIZ_RST;
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    assign tx_p    = q.p;
    assign tx_n    = q.n;
    assign tx_oe_n = q.oe_n;
    assign overrun = q.ovr;

    a_lsb_first: assert property (@(posedge clock) disable iff (reset)
        load && !w.code |=> tx_p == $past(lsb_in))
        else $error("first serial bit is not bit 0");

    a_word_tail: assert property (@(posedge clock) disable iff (reset)
        load && !w.code |-> ##10 tx_p == $past(msb_in, 10))
        else $error("tenth serial bit is not bit 9");

    sequence s_k285_neg;
        load && w.code && w.word[8:0] == 9'h1BC && !q.rd;
    endsequence

    a_k_encode: assert property (@(posedge clock) disable iff (reset)
        s_k285_neg |=> !tx_p ##1 !tx_p ##1 tx_p)
        else $error("control code start bits wrong");

endmodule : txc_chan_tx

//--- core/txc_ddr_lane.sv
`timescale 1ns/1ps
module txc_ddr_lane
    import txc_pkg::*;
(
    input  wire logic        lclk,
    input  wire logic        reset,
    input  wire logic [9:0]  bus,
    txc_pair_if.lane         pr
);

    typedef struct packed {
        logic [1:0]  rst_s;
        logic        have_rise;
        logic [9:0]  rise_hold;
        logic [9:0]  rise;
        logic [9:0]  fall;
        logic        tgl;
    } txc_lane_st_t;

    txc_lane_st_t q;
    txc_lane_st_t d;
    logic [9:0]   fall_cap;
    logic         lrst;

    assign lrst = q.rst_s[1];

    // Falling half lives apart; one negedge flop, read on the next rise
    always_ff @(negedge lclk) begin
        fall_cap <= bus;
    end

    // ==========================================================
    // Pair rising word with the falling word that follows it
    always_comb begin
        d = q;
        if (q.have_rise) begin
            d.rise = q.rise_hold;
            d.fall = fall_cap;
            d.tgl  = ~q.tgl;
        end
        d.rise_hold = bus;
        d.have_rise = 1'b1;
        if (lrst)
            d = '0;
        d.rst_s = {q.rst_s[0], reset};
    end

    always_ff @(posedge lclk) begin
        q <= d;
    end

    assign pr.tgl  = q.tgl;
    assign pr.rise = q.rise;
    assign pr.fall = q.fall;

    a_pair_toggle: assert property (@(posedge lclk) disable iff (lrst)
        q.have_rise |=> $changed(q.tgl) && q.rise == $past(q.rise_hold))
        else $error("lane did not publish pair");

endmodule : txc_ddr_lane

//--- core/txc_tx_capture.sv
`timescale 1ns/1ps
module txc_tx_capture
    import txc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        serial_loop_pin,
    input  wire logic [3:0]  channel_loopback,
    input  wire logic        nibble_mode,
    input  wire logic        channel_independent,
    input  wire logic        code_select,
    input  wire logic        common_tx_clock,
    input  wire logic        pair_cd_tx_clock,
    input  wire logic [9:0]  tx_bus_ab,
    input  wire logic [9:0]  tx_bus_cd,
    output logic      [3:0]  tx_p,
    output logic      [3:0]  tx_n,
    output logic      [3:0]  tx_oe_n,
    output logic      [3:0]  overrun
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [1:0]        loop_s;
        logic [1:0]        nib_s;
        logic [1:0]        ind_s;
        logic [1:0]        code_s;
        logic [2:0]        ab_t;
        logic [2:0]        cdc_t;
        logic [2:0]        cdp_t;
        logic [19:0]       ab_pair;
        logic [19:0]       cd_pair;
        logic              ab_new;
        logic              cd_new;
        logic [3:0]        val;
        logic [3:0][9:0]   word;
    } txc_top_st_t;

    txc_top_st_t  q;
    txc_top_st_t  d;
    logic         ab_ev;
    logic         cdc_ev;
    logic         cdp_ev;
    logic         cd_ev;
    logic         nib;
    logic         ind;

    txc_pair_if   ab_pr ();
    txc_pair_if   cdc_pr ();
    txc_pair_if   cdp_pr ();
    txc_word_if   chw [TXC_NCH] ();

    // ==========================================================
    // Word split per interface mode; index 0 is A or C
    function automatic logic [9:0] txc_unpack(logic n, logic up,
                                              logic [9:0] r,
                                              logic [9:0] f);
        if (!n)
            return up ? r : f;
        // Rising half gives the high nibble of each field
        // Line 3 rising lands on word bit 8, the lower K flag
        // Line 8 feeds bits 8 and 3 of the upper word
        return up ? {r[9:5], f[9:5]}
                  : {r[4:0], f[4:0]};
    endfunction : txc_unpack

    // ==========================================================
    // Capture lanes
    // C/D bus is captured in both domains; the mode picks one.
    // Avoids muxing clocks at the cost of one spare lane.
    txc_ddr_lane u_ab (
        .lclk  (common_tx_clock),
        .reset (reset),
        .bus   (tx_bus_ab),
        .pr    (ab_pr)
    );

    txc_ddr_lane u_cd_common (
        .lclk  (common_tx_clock),
        .reset (reset),
        .bus   (tx_bus_cd),
        .pr    (cdc_pr)
    );

    txc_ddr_lane u_cd_pair (
        .lclk  (pair_cd_tx_clock),
        .reset (reset),
        .bus   (tx_bus_cd),
        .pr    (cdp_pr)
    );

    // ==========================================================
    // Crossing and mode decode
    // Pair data holds a whole link period, longer than the
    // three-flop toggle path at this clock rate.
    assign nib    = q.nib_s[1];
    assign ind    = q.ind_s[1];
    assign ab_ev  = q.ab_t[1] ^ q.ab_t[2];
    assign cdc_ev = q.cdc_t[1] ^ q.cdc_t[2];
    assign cdp_ev = q.cdp_t[1] ^ q.cdp_t[2];
    assign cd_ev  = ind ? cdp_ev : cdc_ev;

    always_comb begin
        d = q;
        // Mode pins are assumed quiet while traffic flows
        d.loop_s = {q.loop_s[0], serial_loop_pin};
        d.nib_s  = {q.nib_s[0], nibble_mode};
        d.ind_s  = {q.ind_s[0], channel_independent};
        d.code_s = {q.code_s[0], code_select};
        d.ab_t   = {q.ab_t[1], q.ab_t[0], ab_pr.tgl};
        d.cdc_t  = {q.cdc_t[1], q.cdc_t[0], cdc_pr.tgl};
        d.cdp_t  = {q.cdp_t[1], q.cdp_t[0], cdp_pr.tgl};
        d.ab_new = ab_ev;
        d.cd_new = cd_ev;
        if (ab_ev)
            d.ab_pair = {ab_pr.rise, ab_pr.fall};
        if (cd_ev) begin
            if (ind)
                d.cd_pair = {cdp_pr.rise, cdp_pr.fall};
            else
                d.cd_pair = {cdc_pr.rise, cdc_pr.fall};
        end
        d.val = 4'h0;
        if (q.ab_new) begin
            d.word[0] = txc_unpack(nib, 1'b0, q.ab_pair[19:10],
                                   q.ab_pair[9:0]);
            d.word[1] = txc_unpack(nib, 1'b1, q.ab_pair[19:10],
                                   q.ab_pair[9:0]);
            d.val[1:0] = 2'h3;
        end
        if (q.cd_new) begin
            d.word[2] = txc_unpack(nib, 1'b0, q.cd_pair[19:10],
                                   q.cd_pair[9:0]);
            d.word[3] = txc_unpack(nib, 1'b1, q.cd_pair[19:10],
                                   q.cd_pair[9:0]);
            d.val[3:2] = 2'h3;
        end
        if (reset) begin
            d = '0;
            d.loop_s = {q.loop_s[0], serial_loop_pin};
            d.nib_s  = {q.nib_s[0], nibble_mode};
            d.ind_s  = {q.ind_s[0], channel_independent};
            d.code_s = {q.code_s[0], code_select};
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    // ==========================================================
    // Serial channels A to D
    for (genvar g = 0; g < TXC_NCH; g++) begin : g_ch
        assign chw[g].valid = q.val[g];
        assign chw[g].word  = q.word[g];
        assign chw[g].code  = q.code_s[1];
        // Float while looped, globally or per channel
        assign chw[g].hiz   = q.loop_s[1]
                              | channel_loopback[g];

        txc_chan_tx u_ch (
            .clock   (clock),
            .reset   (reset),
            .w       (chw[g]),
            .tx_p    (tx_p[g]),
            .tx_n    (tx_n[g]),
            .tx_oe_n (tx_oe_n[g]),
            .overrun (overrun[g])
        );
    end

    // ==========================================================
    // Checks
    a_oe_loop_pin: assert property (@(posedge clock) disable iff (reset)
        q.loop_s[1] |=> tx_oe_n == 4'hF)
        else $error("outputs driven while loop pin high");

    a_oe_chan_bit: assert property (@(posedge clock) disable iff (reset)
        ##1 (tx_oe_n & $past(channel_loopback))
            == $past(channel_loopback))
        else $error("looped channel still driven");

    a_oe_release: assert property (@(posedge clock) disable iff (reset)
        !q.loop_s[1] && channel_loopback == 4'h0 |=> tx_oe_n == 4'h0)
        else $error("output left floating");

    a_mux_order: assert property (@(posedge clock) disable iff (reset)
        q.ab_new && !nib |=> q.word[1] == $past(q.ab_pair[19:10])
            && q.word[0] == $past(q.ab_pair[9:0]))
        else $error("multiplexed A/B split wrong");

    a_nib_order: assert property (@(posedge clock) disable iff (reset)
        q.cd_new && nib |=> q.word[2] == {$past(q.cd_pair[14:10]),
            $past(q.cd_pair[4:0])})
        else $error("nibble order wrong on C");

    a_nib_upper: assert property (@(posedge clock) disable iff (reset)
        q.cd_new && nib |=> q.word[3] == {$past(q.cd_pair[19:15]),
            $past(q.cd_pair[9:5])})
        else $error("nibble field of D wrong");

    a_cd_indep: assert property (@(posedge clock) disable iff (reset)
        ind && $stable(ind) && cdc_ev && !cdp_ev |=> !q.cd_new)
        else $error("common clock fed C/D in independent mode");

    a_cd_sync: assert property (@(posedge clock) disable iff (reset)
        !ind && $stable(ind) && cdp_ev && !cdc_ev |=> !q.cd_new)
        else $error("pair clock fed C/D in synchronized mode");

    sequence s_ab_arrive;
        ab_ev ##1 q.ab_new;
    endsequence

    a_ab_handoff: assert property (@(posedge clock) disable iff (reset)
        s_ab_arrive |=> q.val[1:0] == 2'h3)
        else $error("A/B pair not handed to channels");

endmodule : txc_tx_capture

//--- include/txc_ifs.sv
`timescale 1ns/1ps
// ==========================================================
// One published rising/falling pair from a capture lane
interface txc_pair_if;
    logic        tgl;
    logic [9:0]  rise;
    logic [9:0]  fall;
    modport lane (output tgl, rise, fall);
    modport core (input  tgl, rise, fall);
endinterface : txc_pair_if

// ==========================================================
// One channel word handed to the serial stage
interface txc_word_if;
    logic        valid;
    logic [9:0]  word;
    logic        code;
    logic        hiz;
    modport src (output valid, word, code, hiz);
    modport dst (input  valid, word, code, hiz);
endinterface : txc_word_if

//--- include/txc_pkg.sv
// Summary of operation
// - Serial outputs float when loop pin high or channel loopback bit set.
// - Synchronized modes: common clock captures every bus on both edges.
// - Independent mode: A/B on common clock, C/D bus on its own pair clock.
// - Each word is serialized with bus bit 0 sent first.
// - Multiplexed mode: B on rising edge, A on falling edge of A/B bus.
// - Multiplexed mode: D on rising edge, C on falling edge of C/D bus.
// - Nibble mode: high nibble on rising edge, low nibble on falling edge.
// - Nibble mode: C uses lines 4 to 0, D uses lines 9 to 5.
// - Nibble mode with encoder: line 3 flags K for channel A or C.
// - Multiplexed mode: line 8 is bit nine raw, or K flag when encoding.
// - Nibble mode: line 8 carries bits four and nine of B, or its K flag.
// - Multiplexed mode: line 9 is bit ten raw; ignored (float or low) when encoding.
// - Select input chooses raw 10-bit groups or bytes through 8b/10b encoder.
package txc_pkg;

    // ==========================================================
    // Widths and counts
    localparam int          TXC_W         = 10;
    localparam int          TXC_NCH       = 4;
    localparam int          TXC_K_BIT     = 8;
    localparam logic [3:0]  TXC_BITS_LAST = 4'h9;
    localparam int          TXC_CLK_NS    = 10;
    localparam int          TXC_REF_MIN   = 100;
    localparam int          TXC_REF_MAX   = 130;

    // ==========================================================
    // Reset values
    localparam logic        TXC_RD_RST    = 1'b0;
    localparam logic        TXC_HIZ_RST   = 1'b1;

    // ==========================================================
    // 8b/10b code tables, negative disparity forms, a or f at MSB
    localparam logic [4:0]  TXC_K28    = 5'h1C;
    localparam logic [5:0]  TXC_K28_6B = 6'h0F;
    localparam logic [3:0]  TXC_ALT4   = 4'h7;
    localparam logic [5:0]  TXC_T6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0]  TXC_T4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

    typedef enum logic {TXC_IDLE, TXC_SHIFT} txc_ser_t;

    // Returns {disparity after, code with bit a at bit 0}
    function automatic logic [10:0] txc_enc(logic [7:0] b, logic k,
                                            logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic [9:0] c;
        logic [9:0] r;
        logic       rdm;
        logic       alt;
        s6 = (k && b[4:0] == TXC_K28) ? TXC_K28_6B : TXC_T6[b[4:0]];
        rdm = 1'b1;
        if (!k) begin
            if (rd && ($countones(s6) != 3 || b[4:0] == 5'h07))
                s6 = ~s6;
            rdm = ($countones(s6) == 3) ? rd : ~rd;
        end
        alt = (b[7:5] == 3'h7) && (k
            || (!rdm && (b[4:0] == 5'h11 || b[4:0] == 5'h12
                         || b[4:0] == 5'h14))
            || (rdm && (b[4:0] == 5'h0B || b[4:0] == 5'h0D
                        || b[4:0] == 5'h0E)));
        s4 = alt ? TXC_ALT4 : TXC_T4[b[7:5]];
        if (rdm && ($countones(s4) != 2 || b[7:5] == 3'h3))
            s4 = ~s4;
        c = {s6, s4};
        // Control codes come from one table; the positive form inverts
        if (k && rd)
            c = ~c;
        for (int i = 0; i < 10; i++)
            r[i] = c[9 - i];
        return {(($countones(c) == 5) ? rd : ~rd), r};
    endfunction : txc_enc

endpackage : txc_pkg

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import txc_pkg::*;
    localparam logic [39:0] JUNK = {4{10'h0B5}};
    logic        clock, reset, serial_loop_pin, nibble_mode;
    logic        channel_independent, code_select, clk_c, clk_p, pn_bad;
    logic [3:0]  channel_loopback, tx_p, tx_n, tx_oe_n, overrun;
    logic [9:0]  ab_c, cd_c, cd_p, tx_bus_cd;
    logic [25:0] cap [4];
    logic [39:0] prv;
    logic [39:0] raw_in [2];
    logic [39:0] enc_in [2];
    int          n_errors, check_count, cycles;

    assign tx_bus_cd = channel_independent ? cd_p : cd_c;

    txc_mac_model i_txc_mac_model_common (
        .lclk (clk_c), .bus_x (ab_c), .bus_y (cd_c));
    txc_mac_model i_txc_mac_model_pair (
        .lclk (clk_p), .bus_x (), .bus_y (cd_p));

    txc_tx_capture i_txc_tx_capture (
        .clock               (clock),
        .reset               (reset),
        .serial_loop_pin     (serial_loop_pin),
        .channel_loopback    (channel_loopback),
        .nibble_mode         (nibble_mode),
        .channel_independent (channel_independent),
        .code_select         (code_select),
        .common_tx_clock     (clk_c),
        .pair_cd_tx_clock    (clk_p),
        .tx_bus_ab           (ab_c),
        .tx_bus_cd           (tx_bus_cd),
        .tx_p                (tx_p),
        .tx_n                (tx_n),
        .tx_oe_n             (tx_oe_n),
        .overrun             (overrun)
    );

    // ==========================================================
    // Clock, timeout and reporting
    initial clock = 1'b0;
    always #5 clock = ~clock;

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // ==========================================================
    // Bus transfers
    task automatic do_reset();
        @(posedge clock);
        reset <= 1'b1;
        fork
            i_txc_mac_model_common.idle(4);
            i_txc_mac_model_pair.idle(4);
        join
        @(posedge clock);
        reset <= 1'b0;
        fork
            i_txc_mac_model_common.idle(3);
            i_txc_mac_model_pair.idle(3);
        join
        @(posedge clock);
        #1;
        check({tx_oe_n, overrun}, 8'h00);
    endtask : do_reset

    // Rising edge publishes the previous pair; capture its serial bits
    task automatic xfer(input logic pr, input logic [39:0] nw);
        if (pr) begin
            i_txc_mac_model_pair.edge_to(1'b1, 10'h0B5, nw[19:10]);
            i_txc_mac_model_pair.edge_to(1'b0, 10'h0B5, nw[9:0]);
        end else begin
            i_txc_mac_model_common.edge_to(1'b1, nw[39:30], nw[19:10]);
            i_txc_mac_model_common.edge_to(1'b0, nw[29:20], nw[9:0]);
        end
        pn_bad = 1'b0;
        for (int i = 0; i < 26; i++) begin
            @(posedge clock);
            #1;
            for (int ch = 0; ch < 4; ch++)
                cap[ch][i] = tx_p[ch];
            if (tx_n !== ~tx_p || tx_oe_n !== 4'h0)
                pn_bad = 1'b1;
        end
        check({31'h0, pn_bad}, 32'h0);
    endtask : xfer

    function automatic logic [9:0] lane_word(input int ch,
                                             input logic [39:0] v);
        logic [9:0] r;
        logic [9:0] f;
        r = (ch < 2) ? v[39:30] : v[19:10];
        f = (ch < 2) ? v[29:20] : v[9:0];
        if (nibble_mode)
            return ch[0] ? {r[9:5], f[9:5]} : {r[4:0], f[4:0]};
        return ch[0] ? r : f;
    endfunction : lane_word

    // Word must follow idle zeros, first bit in the lowest position
    task automatic expect_word(input int ch, input logic [9:0] w);
        logic hit;
        logic clean;
        hit = 1'b0;
        for (int off = 0; off <= 16; off++) begin
            clean = 1'b1;
            for (int j = 0; j < off; j++)
                clean &= ~cap[ch][j];
            if (clean && cap[ch][off +: 10] === w)
                hit = 1'b1;
        end
        check({31'h0, hit}, 32'h1);
    endtask : expect_word

    task automatic step(input logic pr, input logic [39:0] nw,
                        input logic chk);
        xfer(pr, nw);
        if (chk)
            for (int ch = 0; ch < 4; ch++)
                expect_word(ch, lane_word(ch, prv));
        prv = nw;
    endtask : step

    // ==========================================================
    // Scenarios
    initial begin
        reset = 1'b1;
        serial_loop_pin = 1'b0;
        channel_loopback = 4'h0;
        nibble_mode = 1'b0;
        channel_independent = 1'b0;
        code_select = 1'b0;
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        prv = JUNK;
        raw_in = '{{10'h201, 10'h3FE, 10'h0CF, 10'h155},
                   {10'h1E3, 10'h30C, 10'h3FF, 10'h2AA}};
        enc_in = '{{10'h0B5, 10'h1BC, 10'h1BC, 10'h0B5},
                   {10'h0AD, 10'h2BC, 10'h1A5, 10'h395}};
        #3;
        for (int m = 0; m < 2; m++) begin
            @(posedge clock);
            nibble_mode <= m[0];
            do_reset();
            step(1'b0, JUNK, 1'b0);
            step(1'b0, raw_in[0], 1'b0);
            step(1'b0, raw_in[1], 1'b1);
            step(1'b0, JUNK, 1'b1);
        end
        @(posedge clock);
        channel_loopback <= 4'h5;
        repeat (3) @(posedge clock);
        #1;
        check(tx_oe_n, 4'h5);
        @(posedge clock);
        serial_loop_pin <= 1'b1;
        repeat (5) @(posedge clock);
        #1;
        check(tx_oe_n, 4'hF);
        @(posedge clock);
        serial_loop_pin <= 1'b0;
        channel_loopback <= 4'h0;
        repeat (5) @(posedge clock);
        #1;
        check(tx_oe_n, 4'h0);
        // Encoder: K28.5 on A and D, D21.5 on B and C
        for (int m = 0; m < 2; m++) begin
            @(posedge clock);
            nibble_mode <= m[0];
            code_select <= 1'b1;
            do_reset();
            step(1'b0, JUNK, 1'b0);
            step(1'b0, enc_in[m], 1'b0);
            step(1'b0, JUNK, 1'b0);
            for (int ch = 0; ch < 4; ch++)
                expect_word(ch, (ch == 0 || ch == 3) ? 10'h17C
                                                     : 10'h155);
        end
        @(posedge clock);
        nibble_mode <= 1'b0;
        code_select <= 1'b0;
        channel_independent <= 1'b1;
        do_reset();
        step(1'b0, JUNK, 1'b0);
        step(1'b1, JUNK, 1'b0);
        step(1'b0, raw_in[0], 1'b0);
        step(1'b0, JUNK, 1'b0);
        expect_word(0, raw_in[0][29:20]);
        expect_word(1, raw_in[0][39:30]);
        check(cap[2] | cap[3], 32'h0);
        step(1'b1, raw_in[1], 1'b0);
        step(1'b1, JUNK, 1'b0);
        expect_word(2, raw_in[1][9:0]);
        expect_word(3, raw_in[1][19:10]);
        check(cap[0] | cap[1], 32'h0);
        // Back-to-back pairs faster than a word shifts: A/B must overrun,
        // C/D stays clean since the common clock no longer feeds it
        i_txc_mac_model_common.idle(3);
        repeat (20) @(posedge clock);
        #1;
        check(overrun, 4'h3);
        give_verdict();
    end
endmodule : testbench

//--- sim/txc_mac_model.sv
`timescale 1ns/1ps
// ==========================================================
// Controller side: DDR transmit bus with a gated link clock
module txc_mac_model (
    output logic        lclk,
    output logic [9:0]  bus_x,
    output logic [9:0]  bus_y
);
    // Link clock stands still outside frames
    initial begin
        lclk  = 1'b0;
        bus_x = 10'h0B5;
        bus_y = 10'h0B5;
    end

    // Data leads each edge by 8 ns and holds 8 ns, then inverts so a
    // late sample cannot pass by luck
    task automatic edge_to(input logic lvl, input logic [9:0] x,
                           input logic [9:0] y);
        bus_x = x;
        bus_y = y;
        #8;
        lclk = lvl;
        #8;
        bus_x = ~x;
        bus_y = ~y;
    endtask : edge_to

    // Neutral filler; keeps running disparity unchanged if captured
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            edge_to(1'b1, 10'h0B5, 10'h0B5);
            edge_to(1'b0, 10'h0B5, 10'h0B5);
        end
    endtask : idle
endmodule : txc_mac_model
